// [dv/pewc_chipset_model.sv]
// Chipset sleep and wake logic model facing the wake block
`timescale 1ns/1ps
module pewc_chipset_model (
   input wire logic mclk,
   input wire logic button_out_n,
   input wire logic wake_event_out_n,
   output logic sleep_s3_in_n
);
   logic btn_q; // Button level one cycle back
   // System starts in the on state
   initial begin
      sleep_s3_in_n = 1'b1;
      btn_q = 1'b1;
   end
   // A button press toggles on and off; a wake request ends sleep
   always @(posedge mclk) begin
      btn_q <= button_out_n;
      if (btn_q && !button_out_n) begin
         sleep_s3_in_n <= !sleep_s3_in_n;
      end else if (!wake_event_out_n && !sleep_s3_in_n) begin
         sleep_s3_in_n <= 1'b1;
      end
   end
endmodule : pewc_chipset_model

// [dv/tb_top.sv]
// Self-checking bench of the wake block against a behavioural model
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top import pewc_pkg::*;;
   logic mclk, rstn, ce, psel, penable, pwrite, pready, pslverr; // Clock, reset, bus
   logic [11:0] paddr; // Byte address
   logic [31:0] pwdata, prdata; // Bus data
   logic [8:0] wake_src; // Event pulses
   logic kbd_code_valid, mouse_left_click, mouse_right_click, mouse_move; // Key and mouse
   logic [7:0] kbd_code; // Key byte
   logic button_in_n, sleep_s3_in_n, main_supply_ok, standby_return; // Power inputs
   logic wake_event_out_n, button_out_n, supply_on_out_n, irq; // Outputs
   int n_errors, total_checks, cyc, n; // Counters
   logic [8:0] m_stat, m_en; // Model status and enable
   logic m_glob; // Model global enable
   logic [31:0] rdat; // Last read data
   logic err; // Last error flag
   logic [7:0] b; // Random byte
   logic [7:0] pw_base[3] = '{8'h00, 8'h30, 8'h40}; // Store bases
   logic [1:0] rmode[4] = '{2'b00, 2'b01, 2'b11, 2'b11}; // Recovery modes
   logic ruser[4] = '{1'b0, 1'b0, 1'b1, 1'b0}; // User state bits
   int rexp[4] = '{0, 2500, 0, 2500}; // Expected pulse lengths
   pewc_top u_pewc_top (.mclk(mclk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_src(wake_src), .kbd_code_valid(kbd_code_valid),
      .kbd_code(kbd_code), .mouse_left_click(mouse_left_click),
      .mouse_right_click(mouse_right_click), .mouse_move(mouse_move),
      .button_in_n(button_in_n), .sleep_s3_in_n(sleep_s3_in_n),
      .main_supply_ok(main_supply_ok), .standby_return(standby_return),
      .wake_event_out_n(wake_event_out_n), .button_out_n(button_out_n),
      .supply_on_out_n(supply_on_out_n), .irq(irq));
   pewc_chipset_model u_pewc_chipset_model (.mclk(mclk), .button_out_n(button_out_n),
      .wake_event_out_n(wake_event_out_n), .sleep_s3_in_n(sleep_s3_in_n));
   // 25 MHz clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         wrap_up();
      end
   end
   // Counts and verdict
   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // One edge, then let updates land
   task tick;
      @(posedge mclk);
      #1;
   endtask : tick
   // One bus transfer; setup, access, wait for ready
   task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One-cycle event pulse, settled two edges later
   task wev(input logic [8:0] v);
      @(posedge mclk);
      wake_src <= v;
      @(posedge mclk);
      wake_src <= 9'h0;
      m_stat = m_stat | v;
      #1;
      tick();
   endtask : wev
   // One-cycle wake request: mouse, key byte or power return
   task req(input int k, input logic [7:0] c);
      @(posedge mclk);
      mouse_move <= (k == 0);
      kbd_code_valid <= (k == 1);
      kbd_code <= c;
      standby_return <= (k == 2);
      @(posedge mclk);
      mouse_move <= 1'b0;
      kbd_code_valid <= 1'b0;
      standby_return <= 1'b0;
      #1;
   endtask : req
   // Length of the next button pulse in cycles
   task pulse(output int len);
      len = 0;
      for (int i = 0; i < 5 && button_out_n !== 1'b0; i++) tick();
      while (button_out_n === 1'b0 && len < 3000) begin
         tick();
         len++;
      end
   endtask : pulse
   // Expected wake output level
   function logic exp_wake;
      return !(m_glob && |(m_stat & m_en));
   endfunction : exp_wake
   // Main sequence
   initial begin
      {rstn, psel, penable, pwrite, kbd_code_valid, mouse_move, standby_return} = '0;
      {mouse_left_click, mouse_right_click, m_glob} = '0;
      {paddr, pwdata, wake_src, kbd_code, m_stat, m_en} = '0;
      {ce, button_in_n, main_supply_ok} = 3'b111;
      {n_errors, total_checks, cyc} = '0;
      void'($urandom(22));
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      // Reset values and an unmapped place
      apb(0, 8'he0, 8'h00);
      `CHK(rdat, 32'h1)
      apb(1, 8'h10, 8'h5a);
      `CHK(err, 1'b1)
      apb(0, 8'h10, 8'h00);
      `CHK(rdat, 32'h0)
      $display("test reset done");
      // Each source, first disabled, then enabled
      apb(1, 8'hf2, 8'h01);
      m_glob = 1'b1;
      for (int i = 0; i < 9; i++) begin
         apb(1, 8'hf3, 8'hff);
         apb(1, 8'hf4, 8'h01);
         m_stat = 9'h0;
         m_en = 9'($urandom) & ~(9'h1 << i);
         apb(1, 8'hf6, m_en[7:0]);
         apb(1, 8'hf7, {7'h0, m_en[8]});
         wev(9'h1 << i);
         `CHK(wake_event_out_n, exp_wake())
         apb(0, (i < 8) ? 8'hf3 : 8'hf4, 8'h00);
         `CHK(rdat, {24'h0, (i < 8) ? m_stat[7:0] : {7'h0, m_stat[8]}})
         m_en[i] = 1'b1;
         apb(1, (i < 8) ? 8'hf6 : 8'hf7, (i < 8) ? m_en[7:0] : {7'h0, m_en[8]});
         tick();
         tick();
         `CHK(wake_event_out_n, exp_wake())
      end
      // Global enable off, interrupt, clear by one
      apb(1, 8'hf2, 8'h00);
      m_glob = 1'b0;
      tick();
      tick();
      `CHK(wake_event_out_n, 1'b1)
      apb(1, 8'hf9, 8'h01);
      tick();
      tick();
      `CHK(irq, 1'b1)
      apb(1, 8'hf4, 8'h00);
      apb(0, 8'hf4, 8'h00);
      `CHK(rdat, 32'h1)
      apb(1, 8'hf4, 8'h01);
      apb(0, 8'hf4, 8'h00);
      `CHK(rdat, 32'h0)
      `CHK(irq, 1'b0)
      apb(1, 8'hf9, 8'h00);
      wev(9'h100);
      `CHK(irq, 1'b0)
      $display("test events done");
      // Button relay for a random hold
      @(posedge mclk);
      button_in_n <= 1'b0;
      repeat ($urandom_range(20, 5)) begin
         tick();
         `CHK(button_out_n, 1'b0)
      end
      @(posedge mclk);
      button_in_n <= 1'b1;
      #1;
      `CHK(button_out_n, 1'b1)
      `CHK(supply_on_out_n, !sleep_s3_in_n)
      $display("test relay done");
      // Mouse wake, disabled then enabled in any-activity mode
      apb(1, 8'he6, 8'h80);
      apb(1, 8'he0, 8'h03);
      req(0, 8'h00);
      pulse(n);
      `CHK(n, 0)
      apb(1, 8'he0, 8'h23);
      req(0, 8'h00);
      pulse(n);
      `CHK(n, 2500)
      // Any-key wake, enabled then disabled
      apb(1, 8'he0, 8'h41);
      req(1, 8'h45);
      pulse(n);
      `CHK(n, 2500)
      apb(1, 8'he0, 8'h01);
      req(1, 8'h45);
      pulse(n);
      `CHK(n, 0)
      $display("test mouse and key done");
      // Store read back, then a one-key password
      foreach (pw_base[s]) begin
         b = 8'($urandom);
         apb(1, 8'he1, pw_base[s] + 8'h0e);
         apb(1, 8'he2, b);
         apb(0, 8'he2, 8'h00);
         `CHK(rdat, {24'h0, b})
      end
      for (int j = 0; j < 15; j++) begin
         apb(1, 8'he1, 8'(j));
         apb(1, 8'he2, (j == 1) ? 8'hf0 : ((j == 0 || j == 2) ? 8'h45 : 8'h00));
      end
      apb(1, 8'he0, 8'h40);
      req(1, 8'h45);
      req(1, 8'hf0);
      req(1, 8'h45);
      pulse(n);
      `CHK(n, 2500)
      // Clock enable low freezes a register write
      ce <= 1'b0;
      apb(1, 8'he1, 8'h77);
      ce <= 1'b1;
      apb(0, 8'he1, 8'h00);
      `CHK(rdat, 32'h0e)
      $display("test password done");
      // Power return in each recovery mode
      for (int m = 0; m < 4; m++) begin
         apb(1, 8'he4, {1'b0, rmode[m], 5'h0});
         apb(1, 8'he6, {3'b100, ruser[m], 4'h0});
         req(2, 8'h00);
         pulse(n);
         `CHK(n, rexp[m])
      end
      apb(1, 8'he4, 8'h40);
      rexp[0] = (sleep_s3_in_n === 1'b1) ? 2500 : 0;
      @(posedge mclk);
      main_supply_ok <= 1'b0;
      req(2, 8'h00);
      pulse(n);
      `CHK(n, rexp[0])
      main_supply_ok <= 1'b1;
      $display("test recovery done");
      wrap_up();
   end
endmodule : tb_top

// [hdl/pewc_params.svh]
// Register offsets, field positions, reset values and timing counts of the wake block
`ifndef PEWC_PARAMS_SVH
`define PEWC_PARAMS_SVH
// Register indices; byte address is four times the index
`define PEWC_IDX_KBMS_CTL 8'he0
`define PEWC_IDX_PW_INDEX 8'he1
`define PEWC_IDX_PW_DATA 8'he2
`define PEWC_IDX_RECOVERY 8'he4
`define PEWC_IDX_MISC_CTL 8'he6
`define PEWC_IDX_GLOBAL_EN 8'hf2
`define PEWC_IDX_STAT_LO 8'hf3
`define PEWC_IDX_STAT_HI 8'hf4
`define PEWC_IDX_EN_LO 8'hf6
`define PEWC_IDX_EN_HI 8'hf7
`define PEWC_IDX_MASK_LO 8'hf8
`define PEWC_IDX_MASK_HI 8'hf9
// Field positions
`define PEWC_B_KBD_WAKE_EN 6
`define PEWC_B_MOUSE_WAKE_EN 5
`define PEWC_B_MOUSE_RIGHT 4
`define PEWC_B_MOUSE_SINGLE 1
`define PEWC_B_KBD_ANY_KEY 0
`define PEWC_B_RECOVERY_HI 6
`define PEWC_B_RECOVERY_LO 5
`define PEWC_B_MOUSE_ANY 7
`define PEWC_B_USER_OFF 4
`define PEWC_B_GLOBAL_EN 0
// Reset values
`define PEWC_RST_KBMS_CTL 8'h01
`define PEWC_RST_ZERO 8'h00
// Key code constants and password store geometry
`define PEWC_BREAK_PREFIX 8'hf0
`define PEWC_PW_SLOTS 15
// Wake pulse length on the button output
`define PEWC_CLK_KHZ 25000
`define PEWC_WAKE_PULSE_US 100
`define PEWC_WAKE_PULSE_CYC ((`PEWC_WAKE_PULSE_US * `PEWC_CLK_KHZ) / 1000)
`endif

// [hdl/pewc_password_match.sv]
// Three password key-code stores and their key-stream matcher
`timescale 1ns/1ps
`include "pewc_params.svh"
module pewc_password_match import pewc_pkg::*; (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [7:0] index,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic [7:0] code,
   input wire logic code_valid,
   output logic match
);
   logic [7:0] store [0:2][0:`PEWC_PW_SLOTS-1]; // Key code bytes
   logic [3:0] ptr [0:2]; // Match position per set
   logic [1:0] sel_set; // Set picked by index
   logic sel_ok; // Index hits a storage byte

   // Index to set number, ok flag in bit 2
   function automatic logic [2:0] decode_index(input logic [7:0] idx);
      logic ok;
      ok = (idx[3:0] != 4'hf);
      unique case (idx[7:4])
         4'h0: decode_index = {ok, 2'd0};
         4'h3: decode_index = {ok, 2'd1};
         4'h4: decode_index = {ok, 2'd2};
         default: decode_index = 3'b000;
      endcase
   endfunction : decode_index

   assign {sel_ok, sel_set} = decode_index(index);
   // Out-of-range index reads zero
   assign rdata = sel_ok ? store[sel_set][index[3:0]] : 8'h00;

   // Storage writes through the data register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int s = 0; s < 3; s++) begin
            for (int b = 0; b < `PEWC_PW_SLOTS; b++) begin
               store[s][b] <= 8'h00;
            end
         end
      end else if (ce && wr_en && sel_ok) begin
         store[sel_set][index[3:0]] <= wdata;
      end
   end

   // Byte-by-byte match; each key is make, prefix, make again
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ptr[0] <= 4'h0;
         ptr[1] <= 4'h0;
         ptr[2] <= 4'h0;
         match <= 1'b0;
      end else if (ce) begin
         match <= 1'b0;
         if (code_valid) begin
            for (int s = 0; s < 3; s++) begin
               if (code != 8'h00 && store[s][ptr[s]] == code) begin
                  // End of sequence at last slot or first zero filler
                  if (ptr[s] == 4'(`PEWC_PW_SLOTS - 1) || store[s][ptr[s] + 4'h1] == 8'h00) begin
                     match <= 1'b1;
                     ptr[s] <= 4'h0;
                  end else begin
                     ptr[s] <= ptr[s] + 4'h1;
                  end
               end else if (code != 8'h00 && store[s][0] == code) begin
                  ptr[s] <= 4'h1; // Restart on a first-key hit
               end else begin
                  ptr[s] <= 4'h0;
               end
            end
         end
      end
   end
endmodule : pewc_password_match

// [hdl/pewc_pkg.sv]
// Types shared by the wake block modules
package pewc_pkg;
   // Power-loss recovery choices
   typedef enum logic [1:0] {
      PEWC_REC_OFF = 2'b00,
      PEWC_REC_ON = 2'b01,
      PEWC_REC_PREV = 2'b10,
      PEWC_REC_USER = 2'b11
   } pewc_recovery_e;
   // Button pulse generator states
   typedef enum logic [1:0] {
      PEWC_ST_IDLE = 2'b01,
      PEWC_ST_PULSE = 2'b10
   } pewc_pulse_e;
   // Nine wake sources
   typedef logic [8:0] pewc_events_t;
endpackage : pewc_pkg

// [hdl/pewc_top.sv]
// Wake-event gathering, button relay, power-loss recovery and key/mouse wake
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "pewc_params.svh"
module pewc_top import pewc_pkg::*; (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [8:0] wake_src,
   input wire logic kbd_code_valid,
   input wire logic [7:0] kbd_code,
   input wire logic mouse_left_click,
   input wire logic mouse_right_click,
   input wire logic mouse_move,
   input wire logic button_in_n,
   input wire logic sleep_s3_in_n,
   input wire logic main_supply_ok,
   input wire logic standby_return,
   output logic wake_event_out_n,
   output logic button_out_n,
   output logic supply_on_out_n,
   output logic irq
);
   // Configuration registers
   logic [7:0] kbms_ctl; // Keyboard and mouse wake control
   logic [7:0] pw_index; // Password byte pointer
   logic [7:0] recovery; // Power-loss recovery field
   logic [7:0] misc_ctl; // Mouse any-activity and user state
   logic [7:0] global_en; // Global wake enable
   pewc_events_t status; // Sticky wake status
   pewc_events_t enable; // Per-event wake enable
   pewc_events_t mask; // Interrupt mask
   // Bus decode
   logic [7:0] reg_idx; // Word index of the access
   logic idx_ok; // Upper address bits are zero
   logic hit; // Index maps to a register
   logic wr_stb; // Write takes effect this edge
   logic [7:0] next_rdata; // Read mux output
   logic [7:0] pw_rdata; // Password byte at index
   // Wake logic
   pewc_recovery_e rec_mode; // Decoded recovery mode
   logic last_on; // System state before loss
   logic recover_on; // Recovery asks for power-up
   logic kbd_wake; // Keyboard wake request
   logic kbd_after_prefix; // Previous byte was break prefix
   logic pw_match; // Password sequence matched
   logic mouse_wake; // Mouse wake request
   logic click_seen; // First of a double click
   logic mouse_btn; // Chosen button clicked
   logic mouse_other; // Other button clicked
   pewc_pulse_e pulse_st; // Button pulse state
   logic [11:0] pulse_cnt; // Button pulse length count

   // True when an index names a mapped register
   function automatic logic reg_mapped(input logic [7:0] idx);
      unique case (idx)
         `PEWC_IDX_KBMS_CTL, `PEWC_IDX_PW_INDEX, `PEWC_IDX_PW_DATA,
         `PEWC_IDX_RECOVERY, `PEWC_IDX_MISC_CTL, `PEWC_IDX_GLOBAL_EN,
         `PEWC_IDX_STAT_LO, `PEWC_IDX_STAT_HI, `PEWC_IDX_EN_LO,
         `PEWC_IDX_EN_HI, `PEWC_IDX_MASK_LO, `PEWC_IDX_MASK_HI: reg_mapped = 1'b1;
         default: reg_mapped = 1'b0;
      endcase
   endfunction : reg_mapped

   // Word-aligned decode
   assign reg_idx = paddr[9:2];
   assign idx_ok = (paddr[11:10] == 2'b00);
   assign hit = idx_ok && reg_mapped(reg_idx);
   assign wr_stb = ce && psel && penable && pwrite && hit;
   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   // Read mux, reserved bits read zero
   always_comb begin
      next_rdata = 8'h00;
      if (idx_ok) begin
         unique case (reg_idx)
            `PEWC_IDX_KBMS_CTL: next_rdata = kbms_ctl;
            `PEWC_IDX_PW_INDEX: next_rdata = pw_index;
            `PEWC_IDX_PW_DATA: next_rdata = pw_rdata;
            `PEWC_IDX_RECOVERY: next_rdata = recovery;
            `PEWC_IDX_MISC_CTL: next_rdata = misc_ctl;
            `PEWC_IDX_GLOBAL_EN: next_rdata = global_en;
            `PEWC_IDX_STAT_LO: next_rdata = status[7:0];
            `PEWC_IDX_STAT_HI: next_rdata = {7'h00, status[8]};
            `PEWC_IDX_EN_LO: next_rdata = enable[7:0];
            `PEWC_IDX_EN_HI: next_rdata = {7'h00, enable[8]};
            `PEWC_IDX_MASK_LO: next_rdata = mask[7:0];
            `PEWC_IDX_MASK_HI: next_rdata = {7'h00, mask[8]};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable && !pwrite) begin
         prdata <= {24'h00_0000, next_rdata};
      end
   end

   // Plain read/write configuration registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         kbms_ctl <= `PEWC_RST_KBMS_CTL;
         pw_index <= `PEWC_RST_ZERO;
         recovery <= `PEWC_RST_ZERO;
         misc_ctl <= `PEWC_RST_ZERO;
         global_en <= `PEWC_RST_ZERO;
      end else if (wr_stb) begin
         unique case (reg_idx)
            `PEWC_IDX_KBMS_CTL: kbms_ctl <= pwdata[7:0];
            `PEWC_IDX_PW_INDEX: pw_index <= pwdata[7:0];
            `PEWC_IDX_RECOVERY: recovery <= pwdata[7:0];
            `PEWC_IDX_MISC_CTL: misc_ctl <= pwdata[7:0];
            `PEWC_IDX_GLOBAL_EN: global_en <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Enable and interrupt mask registers, same layout as status
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         enable <= 9'h000;
         mask <= 9'h000;
      end else if (wr_stb) begin
         unique case (reg_idx)
            `PEWC_IDX_EN_LO: enable[7:0] <= pwdata[7:0];
            `PEWC_IDX_EN_HI: enable[8] <= pwdata[0];
            `PEWC_IDX_MASK_LO: mask[7:0] <= pwdata[7:0];
            `PEWC_IDX_MASK_HI: mask[8] <= pwdata[0];
            default: ;
         endcase
      end
   end

   // Sticky status per source; a new event beats a same-cycle clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         status <= 9'h000;
      end else if (ce) begin
         for (int i = 0; i < 9; i++) begin
            if (wake_src[i]) begin
               status[i] <= 1'b1;
            end else if (wr_stb && i < 8 && reg_idx == `PEWC_IDX_STAT_LO && pwdata[i]) begin
               status[i] <= 1'b0;
            end else if (wr_stb && i == 8 && reg_idx == `PEWC_IDX_STAT_HI && pwdata[0]) begin
               status[i] <= 1'b0;
            end
         end
      end
   end

   // Wake output, low only with global and per-event enable
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wake_event_out_n <= 1'b1;
      end else if (ce) begin
         wake_event_out_n <= !(global_en[`PEWC_B_GLOBAL_EN] && |(status & enable));
      end
   end

   // Level interrupt from status bits whose mask bit is set
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(status & mask);
      end
   end

   // Password stores and matcher
   pewc_password_match u_pw (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .wr_en(wr_stb && reg_idx == `PEWC_IDX_PW_DATA),
      .index(pw_index),
      .wdata(pwdata[7:0]),
      .rdata(pw_rdata),
      .code(kbd_code),
      .code_valid(kbd_code_valid && kbms_ctl[`PEWC_B_KBD_WAKE_EN]),
      .match(pw_match)
   );

   // Break-code tracking so any-key wakes only on a make code
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         kbd_after_prefix <= 1'b0;
      end else if (ce && kbd_code_valid) begin
         kbd_after_prefix <= (kbd_code == `PEWC_BREAK_PREFIX);
      end
   end

   // Keyboard wake: any make code or a matched password
   always_comb begin
      kbd_wake = 1'b0;
      if (kbms_ctl[`PEWC_B_KBD_WAKE_EN]) begin
         if (kbms_ctl[`PEWC_B_KBD_ANY_KEY]) begin
            kbd_wake = kbd_code_valid && !kbd_after_prefix && kbd_code != `PEWC_BREAK_PREFIX;
         end else begin
            kbd_wake = pw_match;
         end
      end
   end

   // Mouse button selection
   assign mouse_btn = kbms_ctl[`PEWC_B_MOUSE_RIGHT] ? mouse_right_click : mouse_left_click;
   assign mouse_other = kbms_ctl[`PEWC_B_MOUSE_RIGHT] ? mouse_left_click : mouse_right_click;

   // Mouse wake event choice
   always_comb begin
      mouse_wake = 1'b0;
      if (kbms_ctl[`PEWC_B_MOUSE_WAKE_EN]) begin
         if (misc_ctl[`PEWC_B_MOUSE_ANY]) begin
            mouse_wake = mouse_left_click || mouse_right_click ||
               (kbms_ctl[`PEWC_B_MOUSE_SINGLE] && mouse_move);
         end else if (kbms_ctl[`PEWC_B_MOUSE_SINGLE]) begin
            mouse_wake = mouse_btn;
         end else begin
            mouse_wake = mouse_btn && click_seen;
         end
      end
   end

   // First-click memory for double clicks; other button cancels
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         click_seen <= 1'b0;
      end else if (ce) begin
         if (mouse_other || mouse_wake) begin
            click_seen <= 1'b0;
         end else if (mouse_btn) begin
            click_seen <= 1'b1;
         end
      end
   end

   // Remember whether the system was on while main supply held
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         last_on <= 1'b0;
      end else if (ce && main_supply_ok) begin
         last_on <= sleep_s3_in_n;
      end
   end

   // Recovery decision when standby power returns
   assign rec_mode = pewc_recovery_e'(recovery[`PEWC_B_RECOVERY_HI:`PEWC_B_RECOVERY_LO]);
   always_comb begin
      recover_on = 1'b0;
      if (standby_return) begin
         unique case (rec_mode)
            PEWC_REC_OFF: recover_on = 1'b0;
            PEWC_REC_ON: recover_on = 1'b1;
            PEWC_REC_PREV: recover_on = last_on;
            PEWC_REC_USER: recover_on = !misc_ctl[`PEWC_B_USER_OFF];
         endcase
      end
   end

   // Button pulse generator for wake and recovery
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pulse_st <= PEWC_ST_IDLE;
         pulse_cnt <= 12'h000;
      end else if (ce) begin
         unique case (pulse_st)
            PEWC_ST_IDLE: begin
               pulse_cnt <= 12'h000;
               if (kbd_wake || mouse_wake || recover_on) begin
                  pulse_st <= PEWC_ST_PULSE;
               end
            end
            PEWC_ST_PULSE: begin
               pulse_cnt <= pulse_cnt + 12'h001;
               if (pulse_cnt == 12'(`PEWC_WAKE_PULSE_CYC - 1)) begin
                  pulse_st <= PEWC_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Button relay merged with the wake pulse
   assign button_out_n = button_in_n && pulse_st != PEWC_ST_PULSE;

   // Supply follows the chipset sleep signal
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         supply_on_out_n <= 1'b1;
      end else if (ce) begin
         supply_on_out_n <= !sleep_s3_in_n;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence pulse_start;
      ce && pulse_st == PEWC_ST_IDLE && (kbd_wake || mouse_wake);
   endsequence

   AST_GLOBAL_OFF: assert property ($past(ce) && !$past(global_en[0]) |-> wake_event_out_n)
      else $error("Wake output active with global enable off");
   AST_STATUS_SET: assert property (ce && wake_src != 9'h000 |=> (status & $past(wake_src)) == $past(wake_src))
      else $error("Wake source did not set status");
   AST_W1C: assert property (wr_stb && reg_idx == `PEWC_IDX_STAT_LO && wake_src == 9'h000
      |=> (status[7:0] & $past(pwdata[7:0])) == 8'h00 && status[8] == $past(status[8]))
      else $error("Status write-one-clear misbehaved");
   AST_ENABLE_GATE: assert property ($past(ce) && (($past(status) & $past(enable)) == 9'h000)
      |-> wake_event_out_n)
      else $error("Wake output without enabled status");
   AST_BUTTON: assert property (!button_in_n |-> !button_out_n)
      else $error("Button input low not relayed");
   AST_REC_OFF: assert property (ce && pulse_st == PEWC_ST_IDLE && standby_return &&
      rec_mode == PEWC_REC_OFF && !kbd_wake && !mouse_wake |=> pulse_st == PEWC_ST_IDLE)
      else $error("Recovery off mode powered up");
   AST_REC_USER: assert property (ce && pulse_st == PEWC_ST_IDLE && standby_return &&
      rec_mode == PEWC_REC_USER && !misc_ctl[4] |=> pulse_st == PEWC_ST_PULSE)
      else $error("User-on recovery gave no pulse");
   AST_PULSE: assert property (pulse_start |=> !button_out_n ##0 pulse_cnt == 12'h000)
      else $error("Wake request gave no button pulse");
   AST_PULSE_LEN: assert property (pulse_st == PEWC_ST_PULSE |-> pulse_cnt < 12'(`PEWC_WAKE_PULSE_CYC))
      else $error("Button pulse overran its length");
   AST_KBD_OFF: assert property (!kbms_ctl[6] |-> !kbd_wake)
      else $error("Keyboard wake while disabled");
   AST_MOUSE_OFF: assert property (!kbms_ctl[5] |-> !mouse_wake)
      else $error("Mouse wake while disabled");
   AST_MOUSE_MOVE: assert property (kbms_ctl[5] && misc_ctl[7] && kbms_ctl[1] && mouse_move
      |-> mouse_wake)
      else $error("Movement did not wake in any-activity mode");
endmodule : pewc_top
